// >>> gtm_defines.svh
`ifndef GTM_DEFINES_SVH
`define GTM_DEFINES_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define GTM_CFG_OFS 8'h00
`define GTM_AMODE_OFS 8'h04
`define GTM_BMODE_OFS 8'h08
`define GTM_CTL_OFS 8'h0C
`define GTM_IMR_OFS 8'h18
`define GTM_RIS_OFS 8'h1C
`define GTM_MIS_OFS 8'h20
`define GTM_ICR_OFS 8'h24
`define GTM_AILR_OFS 8'h28
`define GTM_BILR_OFS 8'h2C
`define GTM_AMATCH_OFS 8'h30
`define GTM_BMATCH_OFS 8'h34
`define GTM_APRE_OFS 8'h38
`define GTM_BPRE_OFS 8'h3C
`define GTM_ACNT_OFS 8'h48
`define GTM_BCNT_OFS 8'h4C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define GTM_CTL_A_EN 0
`define GTM_CTL_A_STALL 1
`define GTM_CTL_RTC_EN 4
`define GTM_CTL_A_OTE 5
`define GTM_CTL_B_EN 8
`define GTM_CTL_B_STALL 9
`define GTM_IRQ_TO 0
`define GTM_IRQ_RTC 3

// ----------------------------------------
// Encodings and reset values
// ----------------------------------------
`define GTM_CFG_TMR32 3'h0
`define GTM_CFG_RTC32 3'h1
`define GTM_AMR_ONESHOT 2'h1
`define GTM_AMR_PERIODIC 2'h2
`define GTM_IRQ_IMPL 4'h9
`define GTM_CFG_RST 3'h0
`define GTM_MODE_RST 4'h0
`define GTM_CTL_RST 16'h0000
`define GTM_IMR_RST 4'h0
`define GTM_HALF_RST 16'hFFFF
`define GTM_PRE_RST 8'h00
`define GTM_RTC_FIRST 32'h0000_0001
`define GTM_CNT_ZERO 32'h0000_0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define GTM_RTC_IN_HZ 32768
`define GTM_RTC_OUT_HZ 1
`define GTM_RTC_DIV (`GTM_RTC_IN_HZ / `GTM_RTC_OUT_HZ)

`endif

// >>> gtm_pkg.sv
package gtm_pkg;

    // ----------------------------------------
    // Operating mode, Gray coded along idle -> timer -> clock
    // ----------------------------------------
    typedef enum logic [1:0] {
        GTM_MODE_IDLE = 2'b00,
        GTM_MODE_TMR = 2'b01,
        GTM_MODE_RTC = 2'b11
    } gtm_mode_t;

    // ----------------------------------------
    // Classic Wishbone request from the master
    // ----------------------------------------
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [31:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } gtm_wb_req_t;

endpackage

// >>> gtm_rtc_div.sv
`timescale 1ns/10ps
`include "gtm_defines.svh"

// Counts rising edges of the slow pin clock and emits one tick per DIVIDE edges
module gtm_rtc_div #(
    parameter int unsigned DIVIDE = `GTM_RTC_DIV
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control and pin
    input wire logic run_i,
    input wire logic pin_i,
    // Output tick
    output logic tick_o
);

    localparam logic [15:0] DIV_LAST = 16'(DIVIDE - 1);

    logic pin_prev_reg; // Pin level one cycle ago
    logic [15:0] cnt_reg; // Edges counted so far
    logic tick_reg; // One-cycle tick
    logic pin_rise; // Rising edge of the pin clock
    logic wrap; // Last edge of a second

    assign pin_rise = pin_i & ~pin_prev_reg;
    assign wrap = pin_rise && (cnt_reg == DIV_LAST);
    assign tick_o = tick_reg;

    // Edge counter; held at zero while stopped so each run starts a full second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_prev_reg <= 1'b0;
            cnt_reg <= 16'h0000;
            tick_reg <= 1'b0;
        end else begin
            pin_prev_reg <= pin_i;
            tick_reg <= run_i && wrap;
            if (!run_i) begin
                cnt_reg <= 16'h0000;
            end else if (wrap) begin
                cnt_reg <= 16'h0000;
            end else if (pin_rise) begin
                cnt_reg <= cnt_reg + 16'h0001;
            end
        end
    end

    AST_DIV_TICK: assert property (@(posedge clk_i) disable iff (rst_i)
        tick_o |-> $past(run_i) && $past(pin_i) && !$past(pin_prev_reg) && !$past(tick_o))
        else $error("divider tick without a closing pin edge");

endmodule

// >>> gtm_top.sv
// Our own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "gtm_defines.svh"

// Operation
// - Two 16-bit halves joined into one 32-bit counter
// - Reset: 32-bit timer config, controls cleared, counts and loads all ones
// - Config 0 selects timer, 1 selects clock
// - 32-bit load write fills both load halves
// - Count read returns upper and lower halves joined
// - Only even capture pin used in 32-bit
// - Timer A mode alone picks one-shot or periodic
// - Count down, reload from load after zero
// - One-shot stops and clears its enable bit
// - Zero sets sticky time-out raw flag
// - Unmasked time-out also sets masked flag
// - Trigger pulse one cycle wide at zero
// - Load write while running restarts from it
// - Stall bit freezes the timer count
// - Clock mode counts up, first load one
// - Pin clock divided down to one hertz tick
// - Clock count equal match rolls over to zero
// - Match sets clock raw; if unmasked also masked and interrupt
// - Clear bit clears clock status flags
// - Clock enable overrides both stall bits
module gtm_top #(
    parameter int unsigned RTC_DIVIDE = `GTM_RTC_DIV
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire gtm_pkg::gtm_wb_req_t wb_req_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    // Capture pin carrying the slow clock
    input wire logic capture_compare_pin_i,
    // Events out
    output logic trig_o,
    output logic irq_o
);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [2:0] cfg_reg; // Configuration select
    logic [3:0] amode_reg; // Timer A mode register
    logic [3:0] bmode_reg; // Timer B mode register, unused in 32-bit
    logic [15:0] ctl_reg; // Control bits
    logic [3:0] imr_reg; // Interrupt mask
    logic [3:0] ris_reg; // Raw status
    logic [15:0] ailr_reg; // Timer A interval load
    logic [15:0] bilr_reg; // Timer B interval load
    logic [15:0] amatch_reg; // Timer A match
    logic [15:0] bmatch_reg; // Timer B match
    logic [7:0] apre_reg; // Timer A prescale
    logic [7:0] bpre_reg; // Timer B prescale
    logic [31:0] cnt_reg; // Joined counter, B half on top
    logic rtc_seen_reg; // Clock mode has been entered once
    logic ack_reg; // Bus acknowledge
    logic [31:0] dat_reg; // Bus read data
    logic trig_reg; // Output trigger
    logic irq_reg; // Controller interrupt

    // ----------------------------------------
    // Next values
    // ----------------------------------------
    logic [15:0] ctl_next;
    logic [3:0] ris_next;
    logic [15:0] ailr_next;
    logic [15:0] bilr_next;
    logic [31:0] cnt_next;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire bus_take = wb_req_i.cyc && wb_req_i.stb && !ack_reg;
    wire bus_wr = bus_take && wb_req_i.we;
    wire [7:0] ofs = wb_req_i.adr[7:0];
    wire wr_cfg = bus_wr && (ofs == `GTM_CFG_OFS) && wb_req_i.sel[0];
    wire wr_amode = bus_wr && (ofs == `GTM_AMODE_OFS) && wb_req_i.sel[0];
    wire wr_bmode = bus_wr && (ofs == `GTM_BMODE_OFS) && wb_req_i.sel[0];
    wire wr_ctl = bus_wr && (ofs == `GTM_CTL_OFS);
    wire wr_imr = bus_wr && (ofs == `GTM_IMR_OFS) && wb_req_i.sel[0];
    wire wr_icr = bus_wr && (ofs == `GTM_ICR_OFS) && wb_req_i.sel[0];
    wire wr_ailr = bus_wr && (ofs == `GTM_AILR_OFS);
    wire wr_bilr = bus_wr && (ofs == `GTM_BILR_OFS);
    wire wr_amatch = bus_wr && (ofs == `GTM_AMATCH_OFS);
    wire wr_bmatch = bus_wr && (ofs == `GTM_BMATCH_OFS);
    wire wr_apre = bus_wr && (ofs == `GTM_APRE_OFS) && wb_req_i.sel[0];
    wire wr_bpre = bus_wr && (ofs == `GTM_BPRE_OFS) && wb_req_i.sel[0];

    // Byte-lane merge of write data into an old word
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] mask;
        mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old_v & ~mask) | (new_v & mask);
    endfunction

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    wire gtm_pkg::gtm_mode_t mode = (cfg_reg == `GTM_CFG_TMR32) ? gtm_pkg::GTM_MODE_TMR :
        (cfg_reg == `GTM_CFG_RTC32) ? gtm_pkg::GTM_MODE_RTC : gtm_pkg::GTM_MODE_IDLE;
    wire mode32 = (mode != gtm_pkg::GTM_MODE_IDLE);
    // Only the timer A mode field decides one-shot versus periodic
    wire a_oneshot = (amode_reg[1:0] == `GTM_AMR_ONESHOT);
    wire a_periodic = (amode_reg[1:0] == `GTM_AMR_PERIODIC);
    wire a_en = ctl_reg[`GTM_CTL_A_EN];
    wire any_stall = ctl_reg[`GTM_CTL_A_STALL] || ctl_reg[`GTM_CTL_B_STALL];

    // ----------------------------------------
    // Counter stepping conditions
    // ----------------------------------------
    wire tmr_run = (mode == gtm_pkg::GTM_MODE_TMR) && a_en && (a_oneshot || a_periodic);
    wire tmr_step = tmr_run && !ctl_reg[`GTM_CTL_A_STALL];
    wire cnt_zero = (cnt_reg == `GTM_CNT_ZERO);
    wire to_evt = tmr_step && cnt_zero;
    wire rtc_tick;
    wire rtc_run = (mode == gtm_pkg::GTM_MODE_RTC) && a_en;
    // Clock enable bit lets the clock ignore both stall bits
    wire rtc_step = rtc_run && rtc_tick && (ctl_reg[`GTM_CTL_RTC_EN] || !any_stall);
    wire [31:0] match32 = {bmatch_reg, amatch_reg};
    wire rtc_hit = rtc_step && (cnt_reg == match32);
    wire rtc_first = wr_cfg && (wb_req_i.dat[2:0] == `GTM_CFG_RTC32) && !rtc_seen_reg;
    wire [31:0] load32 = {bilr_reg, ailr_reg};
    wire [31:0] ilr_merge = lane_merge({bilr_reg, ailr_reg}, wb_req_i.dat, wb_req_i.sel);
    wire [31:0] ctl_merge = lane_merge({16'h0000, ctl_reg}, wb_req_i.dat, wb_req_i.sel);
    // Byte-lane merges for the lone halves and for the joined match pair
    wire [31:0] bilr_merge = lane_merge({16'h0000, bilr_reg}, wb_req_i.dat, wb_req_i.sel);
    wire [31:0] match_merge = lane_merge(match32, wb_req_i.dat, wb_req_i.sel);
    wire [31:0] amatch_merge = lane_merge({16'h0000, amatch_reg}, wb_req_i.dat, wb_req_i.sel);
    wire [31:0] bmatch_merge = lane_merge({16'h0000, bmatch_reg}, wb_req_i.dat, wb_req_i.sel);
    wire [3:0] icr_bits = wr_icr ? (wb_req_i.dat[3:0] & `GTM_IRQ_IMPL) : 4'h0;
    wire [3:0] set_bits = {rtc_hit, 2'b00, to_evt};
    wire [3:0] mis = ris_reg & imr_reg;

    // ----------------------------------------
    // Slow clock divider on the even capture pin
    // ----------------------------------------
    gtm_rtc_div #(
        .DIVIDE(RTC_DIVIDE)
    ) u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(rtc_run),
        .pin_i(capture_compare_pin_i),
        .tick_o(rtc_tick)
    );

    // ----------------------------------------
    // Load registers
    // ----------------------------------------
    // A 32-bit load write splits over both halves only in 32-bit modes
    always_comb begin
        ailr_next = ailr_reg;
        bilr_next = bilr_reg;
        if (wr_ailr) begin
            ailr_next = ilr_merge[15:0];
            if (mode32) begin
                bilr_next = ilr_merge[31:16];
            end
        end else if (wr_bilr) begin
            bilr_next = bilr_merge[15:0];
        end
    end

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    // A load write wins over a step so software restarts the period at once
    always_comb begin
        cnt_next = cnt_reg;
        if (wr_ailr && (mode == gtm_pkg::GTM_MODE_TMR)) begin
            cnt_next = {bilr_next, ailr_next};
        end else if (rtc_first) begin
            cnt_next = `GTM_RTC_FIRST;
        end else if (tmr_step) begin
            if (cnt_zero) begin
                cnt_next = load32;
            end else begin
                cnt_next = cnt_reg - 32'h0000_0001;
            end
        end else if (rtc_step) begin
            if (rtc_hit) begin
                cnt_next = `GTM_CNT_ZERO;
            end else begin
                cnt_next = cnt_reg + 32'h0000_0001;
            end
        end
    end

    // ----------------------------------------
    // Control and status
    // ----------------------------------------
    always_comb begin
        ctl_next = wr_ctl ? ctl_merge[15:0] : ctl_reg;
        // One-shot drops its own enable in the same cycle as the zero reload
        if (to_evt && a_oneshot) begin
            ctl_next[`GTM_CTL_A_EN] = 1'b0;
        end
    end

    // Set wins over a clear arriving in the same cycle
    assign ris_next = (ris_reg & ~icr_bits) | set_bits;

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    wire [31:0] acnt_rd = mode32 ? cnt_reg : {16'h0000, cnt_reg[15:0]};
    wire [31:0] rd_data =
        (ofs == `GTM_CFG_OFS) ? {29'h0, cfg_reg} :
        (ofs == `GTM_AMODE_OFS) ? {28'h0, amode_reg} :
        (ofs == `GTM_BMODE_OFS) ? {28'h0, bmode_reg} :
        (ofs == `GTM_CTL_OFS) ? {16'h0000, ctl_reg} :
        (ofs == `GTM_IMR_OFS) ? {28'h0, imr_reg} :
        (ofs == `GTM_RIS_OFS) ? {28'h0, ris_reg} :
        (ofs == `GTM_MIS_OFS) ? {28'h0, mis} :
        (ofs == `GTM_AILR_OFS) ? (mode32 ? load32 : {16'h0000, ailr_reg}) :
        (ofs == `GTM_BILR_OFS) ? {16'h0000, bilr_reg} :
        (ofs == `GTM_AMATCH_OFS) ? (mode32 ? match32 : {16'h0000, amatch_reg}) :
        (ofs == `GTM_BMATCH_OFS) ? {16'h0000, bmatch_reg} :
        (ofs == `GTM_APRE_OFS) ? {24'h0, apre_reg} :
        (ofs == `GTM_BPRE_OFS) ? {24'h0, bpre_reg} :
        (ofs == `GTM_ACNT_OFS) ? acnt_rd :
        (ofs == `GTM_BCNT_OFS) ? {16'h0000, cnt_reg[31:16]} :
        32'h0000_0000;

    // ----------------------------------------
    // Bus slave flops
    // ----------------------------------------
    // Every access, mapped or not, is acknowledged one cycle after it starts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= bus_take;
            if (bus_take && !wb_req_i.we) begin
                dat_reg <= rd_data;
            end
        end
    end

    // ----------------------------------------
    // Configuration flops
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_reg <= `GTM_CFG_RST;
            amode_reg <= `GTM_MODE_RST;
            bmode_reg <= `GTM_MODE_RST;
            imr_reg <= `GTM_IMR_RST;
            apre_reg <= `GTM_PRE_RST;
            bpre_reg <= `GTM_PRE_RST;
            rtc_seen_reg <= 1'b0;
        end else begin
            if (wr_cfg) cfg_reg <= wb_req_i.dat[2:0];
            if (wr_amode) amode_reg <= wb_req_i.dat[3:0];
            if (wr_bmode) bmode_reg <= wb_req_i.dat[3:0];
            if (wr_imr) imr_reg <= wb_req_i.dat[3:0] & `GTM_IRQ_IMPL;
            if (wr_apre) apre_reg <= wb_req_i.dat[7:0];
            if (wr_bpre) bpre_reg <= wb_req_i.dat[7:0];
            if (rtc_first) rtc_seen_reg <= 1'b1;
        end
    end

    // ----------------------------------------
    // Timer datapath flops
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_reg <= `GTM_CTL_RST;
            ris_reg <= 4'h0;
            ailr_reg <= `GTM_HALF_RST;
            bilr_reg <= `GTM_HALF_RST;
            amatch_reg <= `GTM_HALF_RST;
            bmatch_reg <= `GTM_HALF_RST;
            cnt_reg <= {`GTM_HALF_RST, `GTM_HALF_RST};
        end else begin
            ctl_reg <= ctl_next;
            ris_reg <= ris_next;
            ailr_reg <= ailr_next;
            bilr_reg <= bilr_next;
            cnt_reg <= cnt_next;
            // Later clock loads arrive through the match pair
            if (wr_amatch) begin
                {bmatch_reg, amatch_reg} <= mode32 ? match_merge :
                    {bmatch_reg, amatch_merge[15:0]};
            end else if (wr_bmatch) begin
                bmatch_reg <= bmatch_merge[15:0];
            end
        end
    end

    // ----------------------------------------
    // Event outputs
    // ----------------------------------------
    // Interrupt lags the masked status by one cycle to come from a flop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            trig_reg <= to_evt && ctl_reg[`GTM_CTL_A_OTE];
            irq_reg <= |mis;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign trig_o = trig_reg;
    assign irq_o = irq_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_zero_hit;
        to_evt && ctl_reg[`GTM_CTL_A_OTE];
    endsequence

    sequence s_one_pulse;
        trig_o ##1 !trig_o;
    endsequence

    AST_TRIG_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
        s_zero_hit |=> s_one_pulse)
        else $error("trigger is not a single cycle pulse after zero");

    AST_TRIG_CAUSE: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(trig_o) |-> $past(cnt_reg) == 32'h0000_0000)
        else $error("trigger rose without the count at zero");

    AST_RELOAD: assert property (@(posedge clk_i) disable iff (rst_i)
        to_evt && !wr_ailr |=> cnt_reg == $past(load32))
        else $error("counter did not reload after zero");

    AST_DOWN: assert property (@(posedge clk_i) disable iff (rst_i)
        tmr_step && !cnt_zero && !wr_ailr |=> cnt_reg == $past(cnt_reg) - 32'h1)
        else $error("counter did not step down by one");

    AST_ONESHOT: assert property (@(posedge clk_i) disable iff (rst_i)
        to_evt && a_oneshot |=> !ctl_reg[`GTM_CTL_A_EN] ##1 cnt_reg == $past(cnt_reg))
        else $error("one-shot kept running after zero");

    AST_TO_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
        ris_reg[`GTM_IRQ_TO] && !wr_icr |=> ris_reg[`GTM_IRQ_TO])
        else $error("time-out flag dropped without a clear");

    AST_STALL: assert property (@(posedge clk_i) disable iff (rst_i)
        tmr_run && ctl_reg[`GTM_CTL_A_STALL] && !wr_ailr |=> $stable(cnt_reg))
        else $error("stalled timer changed its count");

    AST_RTC_ROLL: assert property (@(posedge clk_i) disable iff (rst_i)
        rtc_hit && !rtc_first |=> cnt_reg == 32'h0 && ris_reg[`GTM_IRQ_RTC])
        else $error("clock match did not roll over and flag");

    AST_RTC_FIRST: assert property (@(posedge clk_i) disable iff (rst_i)
        rtc_first |=> cnt_reg == 32'h0000_0001 && rtc_seen_reg)
        else $error("first clock mode entry did not load one");

    AST_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
        (ris_reg[`GTM_IRQ_RTC] && imr_reg[`GTM_IRQ_RTC]) |=> irq_o)
        else $error("unmasked clock match raised no interrupt");

    AST_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_icr && wb_req_i.dat[`GTM_IRQ_RTC] && !rtc_hit |=> !ris_reg[`GTM_IRQ_RTC])
        else $error("clock flag survived its clear");

    AST_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_take |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer is not a one cycle acknowledge");

endmodule

// >>> gtm_pin_model.sv
`timescale 1ns/10ps

// ----------------------------------------
// Slow clock source on the even capture pin
// ----------------------------------------
module gtm_pin_model #(
    parameter int unsigned HALF = 5
) (
    // Clock and control
    input wire logic clk_i,
    input wire logic run_i,
    // Pin
    output logic pin_o
);
    int unsigned cnt; // Cycles spent in the current half period

    // Held low while stopped, so no stray edge reaches the divider
    always @(posedge clk_i) begin
        if (!run_i) begin
            cnt <= 0;
            pin_o <= 1'h0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            pin_o <= ~pin_o;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// >>> testbench.sv
`timescale 1ns/10ps

module testbench;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam int unsigned DIV = 4; // Short divide keeps clock tests brief
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    gtm_pkg::gtm_wb_req_t req = '0;
    logic ack;
    logic trig;
    logic irq;
    logic pin;
    logic pin_run = 1'h0;
    logic [31:0] rdat;
    logic [31:0] a;
    logic [31:0] b;
    int errors = 0;
    int n_compared = 0;
    int cyc_n = 0;
    int n;

    always #4 clk_i = ~clk_i;

    gtm_top #(.RTC_DIVIDE(DIV)) gtm_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
        .wb_ack_o(ack), .wb_dat_o(rdat), .capture_compare_pin_i(pin), .trig_o(trig),
        .irq_o(irq));
    gtm_pin_model gtm_pin_model_i (.clk_i(clk_i), .run_i(pin_run), .pin_o(pin));

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic summarize();
        $display("errors=%0d n_compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t flag %b exp %b", $time, got, exp);
        end
    endtask

    // One classic cycle; the wait has no own limit, the global timeout cuts a hang
    task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge clk_i);
        req <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: {24'h0, ad}, sel: 4'hF, dat: d};
        do @(posedge clk_i); while (ack !== 1'h1);
        q = rdat;
        req <= '0;
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        logic [31:0] q;
        wb(1'h1, ad, d, q);
    endtask

    task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'h0, ad, 32'h0, q);
        chk32(q, exp);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        rdchk(8'h00, 32'h0);
        rdchk(8'h0C, 32'h0);
        rdchk(8'h28, 32'hFFFF_FFFF);
        rdchk(8'h48, 32'hFFFF_FFFF);
        rdchk(8'h38, 32'h0);
        rdchk(8'h3C, 32'h0);
        // A 16-bit configuration must not join the halves on a count read
        wr(8'h00, 32'h4);
        rdchk(8'h48, 32'h0000_FFFF);
    endtask

    task automatic t_oneshot();
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h1);
        wr(8'h08, 32'h2);
        wr(8'h18, 32'h1);
        wr(8'h28, 32'h0003_0040);
        rdchk(8'h2C, 32'h0000_0003);
        rdchk(8'h48, 32'h0003_0040);
        wr(8'h28, 32'h0000_0040);
        wr(8'h0C, 32'h21);
        n = 0;
        // Count from 0x40 down to zero takes about 65 cycles
        while (trig !== 1'h1 && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        chk1(n > 55 && n < 75, 1'h1);
        @(posedge clk_i);
        chk1(trig, 1'h0);
        rdchk(8'h1C, 32'h1);
        rdchk(8'h20, 32'h1);
        chk1(irq, 1'h1);
        rdchk(8'h0C, 32'h20);
        rdchk(8'h48, 32'h40);
        wr(8'h24, 32'h0);
        rdchk(8'h1C, 32'h1);
        wr(8'h24, 32'h1);
        rdchk(8'h1C, 32'h0);
        chk1(irq, 1'h0);
    endtask

    task automatic t_periodic();
        wr(8'h04, 32'h2);
        wr(8'h28, 32'h100);
        wr(8'h0C, 32'h3);
        wb(1'h0, 8'h48, 32'h0, a);
        wb(1'h0, 8'h48, 32'h0, b);
        chk32(b, a);
        chk32(a, 32'h100);
        wr(8'h0C, 32'h1);
        wb(1'h0, 8'h48, 32'h0, a);
        chk1(a < 32'h100, 1'h1);
        wr(8'h28, 32'h1000);
        wb(1'h0, 8'h48, 32'h0, a);
        chk1(a > 32'hF00 && a <= 32'h1000, 1'h1);
        wr(8'h28, 32'h20);
        // Several wraps pass with the trigger enable off
        repeat (100) begin
            @(posedge clk_i);
            chk1(trig, 1'h0);
        end
        rdchk(8'h1C, 32'h1);
        rdchk(8'h0C, 32'h1);
        wb(1'h0, 8'h48, 32'h0, a);
        chk1(a <= 32'h20, 1'h1);
        wr(8'h0C, 32'h0);
        wr(8'h24, 32'h1);
    endtask

    task automatic t_rtc();
        wr(8'h00, 32'h1);
        rdchk(8'h48, 32'h1);
        wr(8'h30, 32'h3);
        wr(8'h18, 32'h8);
        wr(8'h0C, 32'h13);
        pin_run <= 1'h1;
        n = 0;
        // Ticks come every 40 cycles; three are needed from 1 up to the match
        do begin
            wb(1'h0, 8'h1C, 32'h0, a);
            n++;
        end while (a[3] !== 1'h1 && n < 200);
        chk1(a[3], 1'h1);
        chk1(n > 20, 1'h1);
        rdchk(8'h48, 32'h0);
        rdchk(8'h20, 32'h8);
        chk1(irq, 1'h1);
        wr(8'h24, 32'h8);
        rdchk(8'h1C, 32'h0);
        chk1(irq, 1'h0);
        pin_run <= 1'h0;
    endtask

    // ----------------------------------------
    // Timeout and main sequence
    // ----------------------------------------
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000) begin
            errors++;
            summarize();
        end
    end

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'h0;
        t_reset();
        t_oneshot();
        t_periodic();
        t_rtc();
        summarize();
    end
endmodule
